// ---- ssmt_pkg.sv ----
package ssmt_pkg;

	// Register byte offsets on the AHB-Lite port
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_PIN     = 8'h08;
	localparam logic [7:0] OFS_RATE    = 8'h0C;
	localparam logic [7:0] OFS_FIFOCTL = 8'h10;
	localparam logic [7:0] OFS_TXDATA  = 8'h14;
	localparam logic [7:0] OFS_COUNT   = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_IRQEN   = 8'h20;

	// CTRL fields
	localparam int CTRL_TX_ON   = 0;
	localparam int CTRL_RX_ON   = 1;
	localparam int CTRL_SYNC    = 2;
	localparam int CTRL_MSB     = 3;
	// MODE fields
	localparam int MODE_PRESC   = 0;
	localparam int MODE_BANK    = 2;
	// PIN fields
	localparam int PIN_DRIVE    = 0;
	localparam int PIN_LEVEL    = 1;
	// FIFOCTL fields
	localparam int FC_TX_CLR    = 0;
	localparam int FC_RX_CLR    = 1;
	localparam int FC_THR       = 4;
	localparam int FC_THR_SRC   = 8;
	localparam int FC_ALT_THR   = 12;
	// STATUS and IRQEN share the event bits; BUSY is in STATUS only
	localparam int ST_TX_EMPTY  = 0;
	localparam int ST_TX_END    = 1;
	localparam int ST_BUSY      = 8;

	// Values after reset
	localparam logic [7:0] RST_DIVISOR = 8'hFF;
	localparam logic [7:0] RST_ALT     = 8'hFF;
	localparam logic       RST_CLR     = 1'b1;

	// Threshold per field code
	localparam logic [4:0] THR_CODE0 = 5'h08;
	localparam logic [4:0] THR_CODE1 = 5'h04;
	localparam logic [4:0] THR_CODE2 = 5'h02;
	localparam logic [4:0] THR_CODE3 = 5'h00;

	// Prescaler divide ratios per select code
	localparam logic [6:0] PRESC_DIV0 = 7'h01;
	localparam logic [6:0] PRESC_DIV1 = 7'h04;
	localparam logic [6:0] PRESC_DIV2 = 7'h10;
	localparam logic [6:0] PRESC_DIV3 = 7'h40;

	localparam logic [3:0] BITS_PER_WORD = 4'h8;

	typedef struct packed {
		logic       sync_mode_select;
		logic       msb_first;
		logic       transmit_on;
		logic       rx_on;
		logic [1:0] clock_prescale_select;
		logic       rate_bank_select;
		logic       txd_pin_drive_en;
		logic       txd_pin_level;
		logic       tx_fifo_clear;
		logic       rx_fifo_clear;
		logic [1:0] tx_fifo_threshold;
		logic       tx_threshold_source;
		logic [3:0] alt_threshold;
	} ssmt_cfg_s;

	typedef enum logic [1:0] {
		SH_IDLE,
		SH_LOW,
		SH_HIGH
	} ssmt_state_e;

endpackage : ssmt_pkg

// ---- ssmt_top.sv ----
`timescale 1ns/10ps
// Functional notes
// R1 - Sync mode bit selects clock-synchronous operation
// R2 - Bit order zero shifts LSB first
// R3 - Pin drive and level bits hold line at the level bit
// R4 - Threshold code 00b means eight entries
// R5 - FIFO clear bits empty and hold FIFOs; only the transmit FIFO exists, the receive clear bit has no effect
// R6 - Prescaler code 01b divides peripheral clock four
// R7 - Divisor 74 at 120 MHz gives 100 kbps
// R8 - Bank select zero maps rate to divisor
// R9 - Raise transmit data-empty request for refill
// R10 - Separate transmit-end event after last bit
// R11 - Each event has enable; cleared blocks it
// R12 - Software disables channel before reconfiguring
// R13 - Software disables transmit after last word
// R14 - FIFO accepts words until count reaches 10h
// R15 - Flag clears only by zero after read
// R16 - Master drives clock, data changes per bit
// R17 - Fixed eight data bits, no framing bits
module ssmt_top #(
	parameter int DATA_W = 8,
	parameter int DEPTH  = 16,
	parameter int CNT_W  = 5
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Serial pins
	output logic                   sck_o,
	output logic                   sck_oe,
	output logic                   txd_o,
	output logic                   txd_oe,
	// Interrupt
	output logic                   irq
);

	localparam int PW = $clog2(DEPTH);

	ssmt_pkg::ssmt_cfg_s   cfg_q;
	ssmt_pkg::ssmt_state_e state_q;
	logic [7:0]            divisor_q;
	logic [7:0]            alt_q;
	logic [1:0]            irq_en_q;
	logic [1:0]            status_q;
	logic [1:0]            armed_q;
	logic                  wr_pend_q;
	logic [7:0]            wr_addr_q;
	logic [DATA_W-1:0]     mem_q [DEPTH];
	logic [PW-1:0]         wptr_q;
	logic [PW-1:0]         rptr_q;
	logic [CNT_W-1:0]      cnt_q;
	logic [6:0]            pre_cnt_q;
	logic [8:0]            half_cnt_q;
	logic [DATA_W-1:0]     shreg_q;
	logic [3:0]            bitcnt_q;
	logic                  end_pulse_q;
	logic                  hreadyout_q;
	logic [31:0]           hrdata_q;
	logic                  sck_q;
	logic                  sck_oe_q;
	logic                  txd_q;
	logic                  txd_oe_q;
	logic                  irq_q;

	logic                  acc;
	logic [31:0]           rd_mux;
	logic                  wr_ctrl;
	logic                  wr_mode;
	logic                  wr_pin;
	logic                  wr_rate;
	logic                  wr_fifoctl;
	logic                  wr_txdata;
	logic                  wr_status;
	logic                  wr_irqen;
	logic                  rd_status;
	logic                  full;
	logic                  empty;
	logic                  push;
	logic                  pop;
	logic                  run;
	logic [6:0]            presc_div;
	logic                  tick;
	logic                  half;
	logic [4:0]            thr_val;
	logic [1:0]            ev_set;
	logic [1:0]            ev_clr;
	logic [DATA_W-1:0]     head;
	logic [DATA_W-1:0]     shifted;

	assign hreadyout = hreadyout_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign sck_o     = sck_q;
	assign sck_oe    = sck_oe_q;
	assign txd_o     = txd_q;
	assign txd_oe    = txd_oe_q;
	assign irq       = irq_q;

	// Bus: zero wait states, writes land in the data phase
	assign acc       = hsel & hready & htrans[1];
	assign rd_status = acc & ~hwrite & (haddr[7:0] == ssmt_pkg::OFS_STATUS);

	always_comb begin
		wr_ctrl    = 1'b0;
		wr_mode    = 1'b0;
		wr_pin     = 1'b0;
		wr_rate    = 1'b0;
		wr_fifoctl = 1'b0;
		wr_txdata  = 1'b0;
		wr_status  = 1'b0;
		wr_irqen   = 1'b0;
		if (!wr_pend_q) begin
			wr_ctrl = 1'b0;
		end else if (wr_addr_q == ssmt_pkg::OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_MODE) begin
			wr_mode = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_PIN) begin
			wr_pin = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_RATE) begin
			wr_rate = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_FIFOCTL) begin
			wr_fifoctl = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_TXDATA) begin
			wr_txdata = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_STATUS) begin
			wr_status = 1'b1;
		end else if (wr_addr_q == ssmt_pkg::OFS_IRQEN) begin
			wr_irqen = 1'b1;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[7:0] == ssmt_pkg::OFS_CTRL) begin
			rd_mux[ssmt_pkg::CTRL_TX_ON] = cfg_q.transmit_on;
			rd_mux[ssmt_pkg::CTRL_RX_ON] = cfg_q.rx_on;
			rd_mux[ssmt_pkg::CTRL_SYNC]  = cfg_q.sync_mode_select;
			rd_mux[ssmt_pkg::CTRL_MSB]   = cfg_q.msb_first;
		end else if (haddr[7:0] == ssmt_pkg::OFS_MODE) begin
			rd_mux[ssmt_pkg::MODE_PRESC +: 2] = cfg_q.clock_prescale_select;
			rd_mux[ssmt_pkg::MODE_BANK]       = cfg_q.rate_bank_select;
		end else if (haddr[7:0] == ssmt_pkg::OFS_PIN) begin
			rd_mux[ssmt_pkg::PIN_DRIVE] = cfg_q.txd_pin_drive_en;
			rd_mux[ssmt_pkg::PIN_LEVEL] = cfg_q.txd_pin_level;
		end else if (haddr[7:0] == ssmt_pkg::OFS_RATE) begin
			rd_mux[7:0] = cfg_q.rate_bank_select ? alt_q : divisor_q; // [R8]
		end else if (haddr[7:0] == ssmt_pkg::OFS_FIFOCTL) begin
			rd_mux[ssmt_pkg::FC_TX_CLR]      = cfg_q.tx_fifo_clear;
			rd_mux[ssmt_pkg::FC_RX_CLR]      = cfg_q.rx_fifo_clear;
			rd_mux[ssmt_pkg::FC_THR +: 2]    = cfg_q.tx_fifo_threshold;
			rd_mux[ssmt_pkg::FC_THR_SRC]     = cfg_q.tx_threshold_source;
			rd_mux[ssmt_pkg::FC_ALT_THR +: 4] = cfg_q.alt_threshold;
		end else if (haddr[7:0] == ssmt_pkg::OFS_COUNT) begin
			rd_mux[CNT_W-1:0] = cnt_q; // [R14]
		end else if (haddr[7:0] == ssmt_pkg::OFS_STATUS) begin
			rd_mux[1:0]               = status_q;
			rd_mux[ssmt_pkg::ST_BUSY] = (state_q != ssmt_pkg::SH_IDLE);
		end else if (haddr[7:0] == ssmt_pkg::OFS_IRQEN) begin
			rd_mux[1:0] = irq_en_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= 8'h00;
			hreadyout_q <= 1'b0;
			hrdata_q    <= 32'h0000_0000;
		end else begin
			hreadyout_q <= 1'b1;
			wr_pend_q   <= acc & hwrite;
			wr_addr_q   <= haddr[7:0];
			hrdata_q    <= (acc & ~hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Configuration registers; channel must be off while changed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q               <= '0;
			cfg_q.tx_fifo_clear <= ssmt_pkg::RST_CLR;
			cfg_q.rx_fifo_clear <= ssmt_pkg::RST_CLR;
			divisor_q           <= ssmt_pkg::RST_DIVISOR;
			alt_q               <= ssmt_pkg::RST_ALT;
			irq_en_q            <= 2'b00;
		end else begin
			if (wr_ctrl) begin
				cfg_q.transmit_on      <= hwdata[ssmt_pkg::CTRL_TX_ON];
				cfg_q.rx_on            <= hwdata[ssmt_pkg::CTRL_RX_ON];
				cfg_q.sync_mode_select <= hwdata[ssmt_pkg::CTRL_SYNC]; // [R1]
				cfg_q.msb_first        <= hwdata[ssmt_pkg::CTRL_MSB]; // [R2]
			end
			if (wr_mode) begin
				cfg_q.clock_prescale_select <=
					hwdata[ssmt_pkg::MODE_PRESC +: 2];
				cfg_q.rate_bank_select <= hwdata[ssmt_pkg::MODE_BANK];
			end
			if (wr_pin) begin
				cfg_q.txd_pin_drive_en <= hwdata[ssmt_pkg::PIN_DRIVE];
				cfg_q.txd_pin_level    <= hwdata[ssmt_pkg::PIN_LEVEL];
			end
			if (wr_rate && !cfg_q.rate_bank_select) begin
				divisor_q <= hwdata[7:0]; // [R8]
			end
			if (wr_rate && cfg_q.rate_bank_select) begin
				alt_q <= hwdata[7:0];
			end
			if (wr_fifoctl) begin
				cfg_q.tx_fifo_clear <= hwdata[ssmt_pkg::FC_TX_CLR];
				cfg_q.rx_fifo_clear <= hwdata[ssmt_pkg::FC_RX_CLR];
				cfg_q.tx_fifo_threshold <= hwdata[ssmt_pkg::FC_THR +: 2];
				cfg_q.tx_threshold_source <= hwdata[ssmt_pkg::FC_THR_SRC];
				cfg_q.alt_threshold <= hwdata[ssmt_pkg::FC_ALT_THR +: 4];
			end
			if (wr_irqen) begin
				irq_en_q <= hwdata[1:0]; // [R11]
			end
		end
	end

	// Transmit FIFO; a word written while full is dropped
	assign full  = (cnt_q == CNT_W'(DEPTH)); // [R14]
	assign empty = (cnt_q == '0);
	assign push  = wr_txdata & ~full & ~cfg_q.tx_fifo_clear;
	assign head  = mem_q[rptr_q];

	always_ff @(posedge hclk) begin
		if (push) begin
			mem_q[wptr_q] <= hwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else if (cfg_q.tx_fifo_clear) begin
			wptr_q <= '0; // [R5]
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			if (push) begin
				wptr_q <= wptr_q + PW'(1);
			end
			if (pop) begin
				rptr_q <= rptr_q + PW'(1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CNT_W'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CNT_W'(1);
			end
		end
	end

	// Bit clock: prescaler tick, then half-bit of 2*(divisor+1) ticks
	always_comb begin
		case (cfg_q.clock_prescale_select)
			2'b00:   presc_div = ssmt_pkg::PRESC_DIV0;
			2'b01:   presc_div = ssmt_pkg::PRESC_DIV1; // [R6]
			2'b10:   presc_div = ssmt_pkg::PRESC_DIV2;
			default: presc_div = ssmt_pkg::PRESC_DIV3;
		endcase
	end

	assign tick = (pre_cnt_q == presc_div - 7'h01);
	assign half = tick & (half_cnt_q == {divisor_q, 1'b1}); // [R7]

	// Counters restart while idle so the first half-bit is full length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_q  <= 7'h00;
			half_cnt_q <= 9'h000;
		end else if (state_q == ssmt_pkg::SH_IDLE) begin
			pre_cnt_q  <= 7'h00;
			half_cnt_q <= 9'h000;
		end else begin
			pre_cnt_q <= tick ? 7'h00 : pre_cnt_q + 7'h01;
			if (half) begin
				half_cnt_q <= 9'h000;
			end else if (tick) begin
				half_cnt_q <= half_cnt_q + 9'h001;
			end
		end
	end

	// Shifter
	assign run = cfg_q.transmit_on & cfg_q.sync_mode_select
		& ~cfg_q.tx_fifo_clear; // [R1]
	assign pop = run & ~empty & ((state_q == ssmt_pkg::SH_IDLE)
		| ((state_q == ssmt_pkg::SH_HIGH) & half
		& (bitcnt_q == ssmt_pkg::BITS_PER_WORD - 4'h1)));
	assign shifted = cfg_q.msb_first ? {shreg_q[DATA_W-2:0], 1'b0}
		: {1'b0, shreg_q[DATA_W-1:1]}; // [R2]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q     <= ssmt_pkg::SH_IDLE;
			shreg_q     <= '0;
			bitcnt_q    <= 4'h0;
			sck_q       <= 1'b1;
			txd_q       <= 1'b1;
			end_pulse_q <= 1'b0;
		end else begin
			end_pulse_q <= 1'b0;
			case (state_q)
				ssmt_pkg::SH_IDLE: begin
					sck_q <= 1'b1;
					if (pop) begin
						shreg_q  <= head;
						bitcnt_q <= 4'h0;
						sck_q    <= 1'b0; // [R16]
						txd_q    <= cfg_q.msb_first ? head[DATA_W-1] : head[0];
						state_q  <= ssmt_pkg::SH_LOW;
					end else if (!cfg_q.transmit_on) begin
						txd_q <= cfg_q.txd_pin_drive_en
							? cfg_q.txd_pin_level : 1'b1; // [R3]
					end
				end
				ssmt_pkg::SH_LOW: begin
					if (!run) begin
						sck_q   <= 1'b1;
						state_q <= ssmt_pkg::SH_IDLE;
					end else if (half) begin
						sck_q   <= 1'b1; // [R16]
						state_q <= ssmt_pkg::SH_HIGH;
					end
				end
				ssmt_pkg::SH_HIGH: begin
					if (!run) begin
						state_q <= ssmt_pkg::SH_IDLE;
					end else if (half) begin
						sck_q <= 1'b0;
						if (bitcnt_q != ssmt_pkg::BITS_PER_WORD - 4'h1) begin
							shreg_q  <= shifted;
							bitcnt_q <= bitcnt_q + 4'h1;
							txd_q    <= cfg_q.msb_first
								? shifted[DATA_W-1] : shifted[0];
							state_q  <= ssmt_pkg::SH_LOW;
						end else if (pop) begin
							shreg_q  <= head; // [R17]
							bitcnt_q <= 4'h0;
							txd_q    <= cfg_q.msb_first
								? head[DATA_W-1] : head[0];
							state_q  <= ssmt_pkg::SH_LOW;
						end else begin
							sck_q       <= 1'b1;
							end_pulse_q <= 1'b1; // [R10]
							state_q     <= ssmt_pkg::SH_IDLE;
						end
					end
				end
				default: state_q <= ssmt_pkg::SH_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_oe_q <= 1'b0;
			txd_oe_q <= 1'b0;
		end else begin
			sck_oe_q <= cfg_q.transmit_on & cfg_q.sync_mode_select; // [R16]
			txd_oe_q <= cfg_q.transmit_on | cfg_q.txd_pin_drive_en; // [R3]
		end
	end

	// Events and interrupt
	always_comb begin
		if (cfg_q.tx_threshold_source) begin
			thr_val = {1'b0, cfg_q.alt_threshold};
		end else begin
			case (cfg_q.tx_fifo_threshold)
				2'b00:   thr_val = ssmt_pkg::THR_CODE0; // [R4]
				2'b01:   thr_val = ssmt_pkg::THR_CODE1;
				2'b10:   thr_val = ssmt_pkg::THR_CODE2;
				default: thr_val = ssmt_pkg::THR_CODE3;
			endcase
		end
	end

	assign ev_set[ssmt_pkg::ST_TX_EMPTY] = cfg_q.transmit_on
		& (5'(cnt_q) <= thr_val); // [R9]
	assign ev_set[ssmt_pkg::ST_TX_END]   = end_pulse_q; // [R10]
	// Writing zero only clears a flag that was seen set by a read
	assign ev_clr = {2{wr_status}} & ~hwdata[1:0] & armed_q; // [R15]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= 2'b00;
			armed_q  <= 2'b00;
			irq_q    <= 1'b0;
		end else begin
			status_q <= ev_set | (status_q & ~ev_clr); // [R15]
			armed_q  <= (armed_q & ~ev_clr)
				| ({2{rd_status}} & status_q);
			irq_q    <= |(status_q & irq_en_q); // [R11]
		end
	end

endmodule : ssmt_top

// ---- ssmt_top_asserts.sv ----
`timescale 1ns/10ps
module ssmt_top_asserts (
	// Bus side
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Serial side and interrupt
	input wire logic        sck_o,
	input wire logic        sck_oe,
	input wire logic        txd_o,
	input wire logic        txd_oe,
	input wire logic        irq
);
	logic take;
	logic ctrl_q;
	logic irqen_q;
	assign take = hsel & hready & htrans[1];
	// Marks the data phase of a write, when hwdata is valid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= 1'b0;
			irqen_q <= 1'b0;
		end else begin
			ctrl_q  <= take & hwrite & (haddr[7:0] == ssmt_pkg::OFS_CTRL);
			irqen_q <= take & hwrite & (haddr[7:0] == ssmt_pkg::OFS_IRQEN);
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	hready_up_a: assert property ($past(hresetn) |-> hreadyout)
		else $error("hreadyout low after reset");
	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	rdata_idle_a: assert property (!$past(take && !hwrite) |-> hrdata == 0)
		else $error("hrdata outside read data phase");
	sck_idle_a: assert property (!sck_oe && $past(!sck_oe) |-> sck_o)
		else $error("serial clock not idle high");
	txd_hold_a: assert property (!sck_o && $past(!sck_o) |-> $stable(txd_o))
		else $error("data moved while clock low");
	txd_idle_a: assert property (!txd_oe && $past(!txd_oe) |-> txd_o)
		else $error("undriven data line not high");
	irq_mask_a: assert property (irqen_q && hwdata[1:0] == 2'b00 |-> ##2 !irq)
		else $error("irq high with all sources masked");
	tx_stop_a: assert property (ctrl_q && !(hwdata[0] && hwdata[2])
		|-> ##2 (!sck_oe && sck_o))
		else $error("clock still driven after stop");
	cover property ($fell(sck_o));
	cover property ($rose(irq));
	cover property (ctrl_q);
endmodule : ssmt_top_asserts

// ---- ssmt_rx_model.sv ----
`timescale 1ns/10ps
module ssmt_rx_model (
	// Serial pins from the master
	input wire logic  sck,
	input wire logic  sck_oe,
	input wire logic  txd,
	// Received words and last bit period in ns
	output logic [15:0] rx_log,
	output logic [31:0] rx_n,
	output logic [31:0] rx_per
);
	logic [7:0] sh;
	logic [3:0] nb;
	time        t0;
	initial begin
		rx_log = 16'h0000;
		rx_n = 32'h0000_0000;
		rx_per = 32'h0000_0000;
		sh = 8'h00;
		nb = 4'h0;
		t0 = 0;
	end
	// Rises of an undriven clock line carry no data
	always @(posedge sck) begin
		if (sck_oe) begin
			rx_per = 32'($time - t0);
			t0 = $time;
			sh = {txd, sh[7:1]};
			nb = nb + 4'h1;
			if (nb == 4'h8) begin
				nb = 4'h0;
				rx_log = {rx_log[7:0], sh};
				rx_n = rx_n + 1;
			end
		end
	end
endmodule : ssmt_rx_model

// ---- ssmt_top_tb.sv ----
`timescale 1ns/10ps
module ssmt_top_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic        sck_o;
	logic        sck_oe;
	logic        txd_o;
	logic        txd_oe;
	logic        irq;
	logic [15:0] rx_log;
	logic [31:0] rx_n;
	logic [31:0] rx_per;
	logic [31:0] r;
	int          n_fail;
	int          checks_done;

	ssmt_top i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.sck_o(sck_o), .sck_oe(sck_oe), .txd_o(txd_o), .txd_oe(txd_oe),
		.irq(irq)
	);
	ssmt_rx_model i_rx (
		.sck(sck_o), .sck_oe(sck_oe), .txd(txd_o),
		.rx_log(rx_log), .rx_n(rx_n), .rx_per(rx_per)
	);

	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single transfer; read data lands in r
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk(r[15:0], e);
	endtask : rc

	// Flags clear only when a read has shown them set
	task automatic rd_clr();
		bus(1'b0, ssmt_pkg::OFS_STATUS, 16'h0000);
		wr(ssmt_pkg::OFS_STATUS, 16'h0000);
	endtask : rd_clr

	task automatic tick(input int n);
		repeat (n) @(negedge hclk);
	endtask : tick

	task automatic wait_rx(input logic [31:0] n);
		for (int i = 0; i < 12000 && rx_n !== n; i++)
			@(negedge hclk);
		chk(rx_n[15:0], n[15:0]);
	endtask : wait_rx

	// Word as an LSB-first receiver sees it when sent MSB first
	function automatic logic [7:0] ex(input logic [7:0] b, input logic m);
		logic [7:0] v;
		for (int i = 0; i < 8; i++)
			v[i] = m ? b[7 - i] : b[i];
		return v;
	endfunction : ex

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// A slow word is near 10000 cycles; the rest is short
	initial begin
		repeat (60000) @(posedge hclk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		hresetn = 1'b0;
		n_fail = 0;
		checks_done = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rc(ssmt_pkg::OFS_RATE, 16'h00FF);
		bus(1'b0, ssmt_pkg::OFS_FIFOCTL, 16'h0000);
		chk(16'(r[1:0]), 16'h0003);
		wr(8'h40, 16'hFFFF);
		rc(8'h40, 16'h0000);
		rc(ssmt_pkg::OFS_CTRL, 16'h0000);
		wr(ssmt_pkg::OFS_TXDATA, 16'h0011);
		rc(ssmt_pkg::OFS_COUNT, 16'h0000);
		wr(ssmt_pkg::OFS_CTRL, 16'h0000);
		wr(ssmt_pkg::OFS_MODE, 16'h0001);
		wr(ssmt_pkg::OFS_RATE, 16'h004A);
		rc(ssmt_pkg::OFS_RATE, 16'h004A);
		wr(ssmt_pkg::OFS_MODE, 16'h0005);
		wr(ssmt_pkg::OFS_RATE, 16'h0033);
		rc(ssmt_pkg::OFS_RATE, 16'h0033);
		wr(ssmt_pkg::OFS_MODE, 16'h0001);
		rc(ssmt_pkg::OFS_RATE, 16'h004A);
		wr(ssmt_pkg::OFS_PIN, 16'h0001);
		tick(2);
		chk(16'({txd_oe, txd_o}), 16'h0002);
		wr(ssmt_pkg::OFS_PIN, 16'h0003);
		tick(2);
		chk(16'({txd_oe, txd_o}), 16'h0003);
		wr(ssmt_pkg::OFS_FIFOCTL, 16'h0000);
		for (int i = 0; i < 17; i++)
			wr(ssmt_pkg::OFS_TXDATA, 16'(i));
		rc(ssmt_pkg::OFS_COUNT, 16'h0010);
		wr(ssmt_pkg::OFS_FIFOCTL, 16'h0001);
		rc(ssmt_pkg::OFS_COUNT, 16'h0000);
		wr(ssmt_pkg::OFS_FIFOCTL, 16'h0000);
		for (int i = 0; i < 8; i++)
			wr(ssmt_pkg::OFS_TXDATA, 16'h00AA);
		wr(ssmt_pkg::OFS_CTRL, 16'h0001);
		rd_clr();
		rc(ssmt_pkg::OFS_STATUS, 16'h0001);
		wr(ssmt_pkg::OFS_TXDATA, 16'h00AA);
		rd_clr();
		rc(ssmt_pkg::OFS_STATUS, 16'h0000);
		rc(ssmt_pkg::OFS_COUNT, 16'h0009);
		chk(16'(sck_oe), 16'h0000);
		wr(ssmt_pkg::OFS_CTRL, 16'h0000);
		wr(ssmt_pkg::OFS_FIFOCTL, 16'h0001);
		wr(ssmt_pkg::OFS_FIFOCTL, 16'h0000);
		wr(ssmt_pkg::OFS_TXDATA, 16'h00A5);
		wr(ssmt_pkg::OFS_IRQEN, 16'h0002);
		wr(ssmt_pkg::OFS_CTRL, 16'h0005);
		tick(2);
		chk(16'(irq), 16'h0000);
		wait_rx(1);
		chk(16'(rx_log[7:0]), 16'h00A5);
		chk(rx_per[15:0], 16'h2EE0);
		for (int i = 0; i < 1000 && irq !== 1'b1; i++)
			@(negedge hclk);
		wr(ssmt_pkg::OFS_STATUS, 16'h0000);
		tick(2);
		chk(16'(irq), 16'h0001);
		rc(ssmt_pkg::OFS_STATUS, 16'h0003);
		wr(ssmt_pkg::OFS_STATUS, 16'h0000);
		tick(2);
		chk(16'(irq), 16'h0000);
		rc(ssmt_pkg::OFS_STATUS, 16'h0001);
		for (int m = 0; m < 2; m++) begin
			wr(ssmt_pkg::OFS_CTRL, 16'h0000);
			wr(ssmt_pkg::OFS_MODE, 16'(2 * m));
			wr(ssmt_pkg::OFS_RATE, 16'h0001);
			wr(ssmt_pkg::OFS_TXDATA, 16'h0001);
			wr(ssmt_pkg::OFS_TXDATA, 16'h00C2);
			wr(ssmt_pkg::OFS_CTRL, 16'(5 + 8 * m));
			wait_rx(32'(3 + 2 * m));
			chk(rx_log, {ex(8'h01, m[0]), ex(8'hC2, m[0])});
			chk(rx_per[15:0], (m == 0) ? 16'h0050 : 16'h0500);
		end
		tick(80);
		chk(16'(irq), 16'h0001);
		wr(ssmt_pkg::OFS_CTRL, 16'h0000);
		wr(ssmt_pkg::OFS_IRQEN, 16'h0000);
		tick(3);
		chk(16'(irq), 16'h0000);
		report_and_stop();
	end
endmodule : ssmt_top_tb

bind ssmt_top ssmt_top_asserts i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.sck_o(sck_o), .sck_oe(sck_oe), .txd_o(txd_o), .txd_oe(txd_oe),
	.irq(irq)
);
